// [eep_serial_rw.sv]
`timescale 1ns/100ps
module eep_serial_rw #(
  parameter int WRITE_CYCLES = eep_pkg::WRITE_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic wp_in,
  input wire logic [eep_pkg::CS_W-1:0] chip_select_pins,
  output logic prog_busy
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_RX    = 7'h02,
    ST_RXEND = 7'h04,
    ST_ACK   = 7'h08,
    ST_TX    = 7'h10,
    ST_TXACK = 7'h20,
    ST_PROG  = 7'h40
  } eep_state_t;

  localparam logic [eep_pkg::PROG_W-1:0] PROG_LAST = eep_pkg::PROG_W'(WRITE_CYCLES - 1);

  eep_pkg::eep_bus_t bus;
  eep_state_t state_reg;
  eep_state_t state_next;
  logic [1:0] kind_reg;
  logic [1:0] kind_next;
  logic [2:0] bit_reg;
  logic [2:0] bit_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [eep_pkg::ADDR_W-1:0] addr_reg;
  logic [eep_pkg::ADDR_W-1:0] addr_next;
  logic [eep_pkg::ADDR_W-1:0] addr_inc;
  logic [eep_pkg::BLK_W-1:0] blk_reg;
  logic [eep_pkg::BLK_W-1:0] blk_next;
  logic rw_reg;
  logic rw_next;
  logic mack_reg;
  logic mack_next;
  logic sda_oe_reg;
  logic sda_oe_next;
  logic sda_out_reg;
  logic busy_reg;
  logic busy_next;
  logic [eep_pkg::PROG_W-1:0] prog_cnt_reg;
  logic [eep_pkg::PROG_W-1:0] prog_cnt_next;
  logic [eep_pkg::PAGE_BYTES-1:0] valid_reg;
  logic [eep_pkg::PAGE_BYTES-1:0] valid_next;
  logic buf_we;
  logic commit;
  logic [7:0] mem [0:eep_pkg::ARRAY_DEPTH-1];
  logic [7:0] page_buf [0:eep_pkg::PAGE_BYTES-1];

  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------
  function automatic logic dev_match(input logic [7:0] b, input logic [eep_pkg::CS_W-1:0] cs);
    logic [eep_pkg::CS_W-1:0] sel;
    sel = b[eep_pkg::BLK_LSB +: eep_pkg::CS_W];
    dev_match = (b[7:eep_pkg::DEV_TYPE_LSB] == eep_pkg::DEV_TYPE) &&
                ((sel & eep_pkg::CS_MASK) == (cs & eep_pkg::CS_MASK));
  endfunction

  function automatic logic is_protected(input logic [eep_pkg::ADDR_W-1:0] a, input logic wp);
    is_protected = wp & a[eep_pkg::PROT_BIT];
  endfunction

  // ---------------------------------------------------------------
  // Pin sensing
  // ---------------------------------------------------------------
  eep_bus_sense u_sense (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .wp_in(wp_in),
    .chip_select_pins(chip_select_pins),
    .bus(bus)
  );

  // Counter wraps naturally at the top of the array
  assign addr_inc = addr_reg + 11'h001;

  // ---------------------------------------------------------------
  // Protocol state machine, next values
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    kind_next = kind_reg;
    bit_next = bit_reg;
    shift_next = shift_reg;
    addr_next = addr_reg;
    blk_next = blk_reg;
    rw_next = rw_reg;
    mack_next = mack_reg;
    sda_oe_next = sda_oe_reg;
    prog_cnt_next = prog_cnt_reg;
    valid_next = valid_reg;
    buf_we = 1'b0;
    commit = 1'b0;
    unique case (state_reg)
      ST_IDLE: begin
        sda_oe_next = 1'b0;
      end
      ST_RX: begin
        if (bus.scl_rise) begin
          shift_next = {shift_reg[6:0], bus.sda};
          bit_next = bit_reg + 3'h1;
          if (bit_reg == 3'h7) begin
            state_next = ST_RXEND;
          end
        end
      end
      ST_RXEND: begin
        // Decision is taken on the fall that opens the ninth clock
        if (bus.scl_fall) begin
          unique case (kind_reg)
            eep_pkg::KIND_DEV: begin
              if (dev_match(shift_reg, bus.cs)) begin
                rw_next = shift_reg[eep_pkg::RW_BIT];
                blk_next = shift_reg[eep_pkg::BLK_LSB +: eep_pkg::BLK_W];
                sda_oe_next = 1'b1;
                state_next = ST_ACK;
                shift_next = mem[addr_reg];
              end else begin
                sda_oe_next = 1'b0;
                state_next = ST_IDLE;
              end
            end
            eep_pkg::KIND_WADDR: begin
              addr_next = {blk_reg, shift_reg};
              valid_next = '0;
              sda_oe_next = 1'b1;
              state_next = ST_ACK;
            end
            default: begin
              buf_we = 1'b1;
              valid_next[addr_reg[eep_pkg::PAGE_W-1:0]] = 1'b1;
              addr_next = {addr_reg[eep_pkg::ADDR_W-1:eep_pkg::PAGE_W], addr_reg[eep_pkg::PAGE_W-1:0] + 4'h1};
              sda_oe_next = 1'b1;
              state_next = ST_ACK;
            end
          endcase
        end
      end
      ST_ACK: begin
        if (bus.scl_fall) begin
          bit_next = 3'h0;
          if (rw_reg) begin
            // first read bit right after ack
            sda_oe_next = ~shift_reg[7];
            state_next = ST_TX;
          end else begin
            sda_oe_next = 1'b0;
            kind_next = (kind_reg == eep_pkg::KIND_DEV) ? eep_pkg::KIND_WADDR : eep_pkg::KIND_WDATA;
            state_next = ST_RX;
          end
        end
      end
      ST_TX: begin
        if (bus.scl_fall) begin
          if (bit_reg == 3'h7) begin
            sda_oe_next = 1'b0;
            state_next = ST_TXACK;
          end else begin
            bit_next = bit_reg + 3'h1;
            shift_next = {shift_reg[6:0], 1'b0};
            sda_oe_next = ~shift_reg[6];
          end
        end
      end
      ST_TXACK: begin
        if (bus.scl_rise) begin
          mack_next = ~bus.sda;
        end
        if (bus.scl_fall) begin
          // counter moves past the byte just sent
          addr_next = addr_inc;
          bit_next = 3'h0;
          if (mack_reg) begin
            // next byte on ack; wrap to zero
            shift_next = mem[addr_inc];
            sda_oe_next = ~mem[addr_inc][7];
            state_next = ST_TX;
          end else begin
            sda_oe_next = 1'b0;
            state_next = ST_IDLE;
          end
        end
      end
      ST_PROG: begin
        // bus ignored, polling gets no ack
        sda_oe_next = 1'b0;
        prog_cnt_next = prog_cnt_reg + 24'h000001;
        if (prog_cnt_reg == PROG_LAST) begin
          commit = 1'b1;
          valid_next = '0;
          state_next = ST_IDLE;
        end
      end
      default: begin
        sda_oe_next = 1'b0;
        state_next = ST_IDLE;
      end
    endcase
    // Start and stop take priority over bit handling outside programming
    if (state_reg != ST_PROG) begin
      if (bus.start) begin
        state_next = ST_RX;
        kind_next = eep_pkg::KIND_DEV;
        bit_next = 3'h0;
        sda_oe_next = 1'b0;
      end else if (bus.stop) begin
        sda_oe_next = 1'b0;
        if (|valid_reg) begin
          prog_cnt_next = '0;
          state_next = ST_PROG;
        end else begin
          state_next = ST_IDLE;
        end
      end
    end
    busy_next = (state_next == ST_PROG);
  end

  // ---------------------------------------------------------------
  // Protocol state machine, registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      kind_reg <= eep_pkg::KIND_DEV;
      bit_reg <= 3'h0;
      shift_reg <= 8'h00;
      addr_reg <= eep_pkg::ADDR_RST;
      blk_reg <= '0;
      rw_reg <= 1'b0;
      mack_reg <= 1'b0;
      sda_oe_reg <= eep_pkg::SDA_OE_RST;
      sda_out_reg <= 1'b0;
      busy_reg <= 1'b0;
      prog_cnt_reg <= '0;
      valid_reg <= '0;
    end else if (ce) begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      bit_reg <= bit_next;
      shift_reg <= shift_next;
      addr_reg <= addr_next;
      blk_reg <= blk_next;
      rw_reg <= rw_next;
      mack_reg <= mack_next;
      sda_oe_reg <= sda_oe_next;
      sda_out_reg <= 1'b0;
      busy_reg <= busy_next;
      prog_cnt_reg <= prog_cnt_next;
      valid_reg <= valid_next;
    end
  end

  // ---------------------------------------------------------------
  // Page buffer and array
  // ---------------------------------------------------------------
  // Array content has no reset: it stands for nonvolatile storage
  always_ff @(posedge core_clk) begin
    if (ce && buf_we) begin
      page_buf[addr_reg[eep_pkg::PAGE_W-1:0]] <= shift_reg;
    end
  end

  // All valid slots of an unprotected page land in one edge; the page base is the counter's high part
  always_ff @(posedge core_clk) begin
    if (ce && commit) begin
      for (int i = 0; i < eep_pkg::PAGE_BYTES; i++) begin
        if (valid_reg[i] && !is_protected(addr_reg, bus.wp)) begin
          mem[{addr_reg[eep_pkg::ADDR_W-1:eep_pkg::PAGE_W], eep_pkg::PAGE_W'(i)}] <= page_buf[i];
        end
      end
    end
  end

  // Open drain: only ever drives low
  assign sda_out = sda_out_reg;
  assign sda_oe = sda_oe_reg;
  assign prog_busy = busy_reg;

endmodule

// [eep_pkg.sv]
package eep_pkg;

  // ---------------------------------------------------------------
  // Array organisation
  // ---------------------------------------------------------------
  localparam int ADDR_W = 11;
  localparam int ARRAY_DEPTH = 2048;
  localparam int PAGE_W = 4;
  localparam int PAGE_BYTES = 16;
  localparam int BLK_W = 3;
  localparam int CS_W = 3;
  // Upper half of the array is the write-protected region
  localparam int PROT_BIT = 10;

  // ---------------------------------------------------------------
  // Slave address byte layout
  // ---------------------------------------------------------------
  localparam logic [3:0] DEV_TYPE = 4'hA;
  localparam int DEV_TYPE_LSB = 4;
  localparam int BLK_LSB = 1;
  localparam int RW_BIT = 0;
  // Chip select pins that take part in the compare; none at this capacity
  localparam logic [CS_W-1:0] CS_MASK = 3'h0;

  // ---------------------------------------------------------------
  // Byte kinds received from the master
  // ---------------------------------------------------------------
  localparam logic [1:0] KIND_DEV = 2'h0;
  localparam logic [1:0] KIND_WADDR = 2'h1;
  localparam logic [1:0] KIND_WDATA = 2'h2;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_FREQ_KHZ = 40000;
  localparam int WRITE_TIME_US = 5000;
  localparam int WRITE_CYCLES = WRITE_TIME_US * (CLK_FREQ_KHZ / 1000);
  localparam int PROG_W = 24;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic SDA_OE_RST = 1'b0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 11'h000;

  // Synchronised pin levels and bus events, one core_clk wide
  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
    logic wp;
    logic [CS_W-1:0] cs;
  } eep_bus_t;

endpackage

// [eep_bus_sense.sv]
`timescale 1ns/100ps
module eep_bus_sense (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic wp_in,
  input wire logic [eep_pkg::CS_W-1:0] chip_select_pins,
  output eep_pkg::eep_bus_t bus
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  logic [1:0] prev_reg;
  eep_pkg::eep_bus_t bus_reg;
  eep_pkg::eep_bus_t bus_next;

  // Edge detection looks only at the second stage and its delayed copy
  always_comb begin
    bus_next.scl_rise = sync2_reg[5] & ~prev_reg[1];
    bus_next.scl_fall = ~sync2_reg[5] & prev_reg[1];
    bus_next.start = sync2_reg[5] & prev_reg[1] & prev_reg[0] & ~sync2_reg[4];
    bus_next.stop = sync2_reg[5] & prev_reg[1] & ~prev_reg[0] & sync2_reg[4];
    bus_next.sda = sync2_reg[4];
    bus_next.wp = sync2_reg[3];
    bus_next.cs = sync2_reg[2:0];
  end

  // Idle bus level is high on both lines, so start from there
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1_reg <= 6'h30;
      sync2_reg <= 6'h30;
      prev_reg <= 2'h3;
      bus_reg <= '0;
    end else if (ce) begin
      sync1_reg <= {scl_in, sda_in, wp_in, chip_select_pins};
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg[5:4];
      bus_reg <= bus_next;
    end
  end

  assign bus = bus_reg;

endmodule

// [eep_serial_rw_props.sv]
`timescale 1ns/100ps
module eep_serial_rw_props #(
  parameter int WRITE_CYCLES = 50
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic wp_in,
  input wire logic [eep_pkg::CS_W-1:0] chip_select_pins,
  input wire logic prog_busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [23:0] run_reg;
  logic [23:0] run_next;

  // Busy length counter; holds still while ce freezes the block
  always_comb begin
    run_next = prog_busy ? run_reg + {23'h000000, ce} : 24'h000000;
  end
  always_ff @(posedge core_clk) begin
    run_reg <= rst ? 24'h000000 : run_next;
  end

  sequence busy_run;
    prog_busy [*8];
  endsequence
  sequence drive_hold;
    sda_oe [*8];
  endsequence

  a_busy_silent: assert property (prog_busy |-> !sda_oe)
    else $error("data driven while programming");
  a_busy_exact: assert property ($fell(prog_busy) |-> run_reg == WRITE_CYCLES)
    else $error("programming time wrong");
  a_busy_bound: assert property (run_reg <= WRITE_CYCLES)
    else $error("programming overran");
  a_busy_min: assert property ($rose(prog_busy) |-> busy_run)
    else $error("programming pulse too short");
  a_commit_at_stop: assert property ($rose(prog_busy) |-> scl_in && sda_in)
    else $error("programming began outside a stop");
  a_drive_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data drive changed with clock high");
  a_drive_hold: assert property ($rose(sda_oe) |-> drive_hold)
    else $error("low drive shorter than a bit");
  a_open_drain: assert property (!sda_out)
    else $error("data output not held low");
endmodule

bind eep_serial_rw eep_serial_rw_props #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (
  .core_clk(core_clk),
  .rst(rst),
  .ce(ce),
  .scl_in(scl_in),
  .sda_in(sda_in),
  .sda_out(sda_out),
  .sda_oe(sda_oe),
  .wp_in(wp_in),
  .chip_select_pins(chip_select_pins),
  .prog_busy(prog_busy)
);

// [eep_bus_master.sv]
`timescale 1ns/100ps
module eep_bus_master (
  input wire logic core_clk,
  input wire logic sda_line,
  output logic scl_drv,
  output logic sda_low
);
  // Idle bus: clock high and data released to the pull-up
  initial begin
    scl_drv = 1'b1;
    sda_low = 1'b0;
  end

  // Eight cycles a phase keeps well clear of the sync latency
  task automatic half();
    repeat (8) @(posedge core_clk);
  endtask

  // Data moves mid-low, sampled at the end of clock high
  task automatic put(input logic b, output logic r);
    half();
    sda_low <= ~b;
    half();
    scl_drv <= 1'b1;
    half();
    r = sda_line;
    scl_drv <= 1'b0;
  endtask

  task automatic start();
    half();
    sda_low <= 1'b0;
    half();
    scl_drv <= 1'b1;
    half();
    sda_low <= 1'b1;
    half();
    scl_drv <= 1'b0;
  endtask

  task automatic stop();
    half();
    sda_low <= 1'b1;
    half();
    scl_drv <= 1'b1;
    half();
    sda_low <= 1'b0;
    half();
  endtask

  task automatic wr(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put(v[i], r);
    end
    put(1'b1, r);
    ack = ~r;
  endtask

  task automatic rd(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put(1'b1, v[i]);
    end
    put(last, r);
  endtask
endmodule

// [testbench.sv]
`timescale 1ns/100ps
module testbench;
  logic core_clk;
  logic rst;
  logic ce;
  logic wp_in;
  logic scl_in;
  logic sda_low;
  logic sda_out;
  logic sda_oe;
  logic prog_busy;
  logic sda_line;
  logic ack;
  logic [7:0] d;
  logic [eep_pkg::CS_W-1:0] cs_pins;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;

  // Open-drain wire with pull-up
  assign sda_line = !(sda_low || sda_oe);

  eep_serial_rw #(.WRITE_CYCLES(1000)) uut (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .scl_in(scl_in),
    .sda_in(sda_line),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .wp_in(wp_in),
    .chip_select_pins(cs_pins),
    .prog_busy(prog_busy)
  );

  eep_bus_master mst (
    .core_clk(core_clk),
    .sda_line(sda_line),
    .scl_drv(scl_in),
    .sda_low(sda_low)
  );

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // A hung poll loop must not stall the run
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      errors = errors + 1;
      wrap_up();
    end
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask

  task automatic addr(input logic [10:0] a);
    mst.start();
    mst.wr({eep_pkg::DEV_TYPE, a[10:8], 1'b0}, ack);
    chk1(ack, 1'b1);
    mst.wr(a[7:0], ack);
    chk1(ack, 1'b1);
  endtask

  // poll right after stop
  // Polls until the device answers again
  task automatic poll();
    int n;
    n = 0;
    ack = 1'b0;
    while (!ack && n < 20) begin
      mst.start();
      mst.wr(8'hA0, ack);
      n++;
    end
    mst.stop();
    chk1(ack, 1'b1);
  endtask

  task automatic wr_at(input logic [10:0] a, input logic [7:0] v);
    addr(a);
    mst.wr(v, ack);
    chk1(ack, 1'b1);
    mst.stop();
    poll();
  endtask

  task automatic rd_open(input logic [10:0] a);
    addr(a);
    mst.start();
    mst.wr({eep_pkg::DEV_TYPE, a[10:8], 1'b1}, ack);
    chk1(ack, 1'b1);
  endtask

  task automatic t_byte();
    addr(11'h7F5);
    mst.wr(8'h3C, ack);
    chk1(ack, 1'b1);
    mst.stop();
    chk1(prog_busy, 1'b1);
    mst.start();
    mst.wr(8'hA0, ack);
    chk1(ack, 1'b0);
    mst.stop();
    // Clock enable low must freeze the programming count well past its length
    ce <= 1'b0;
    repeat (2000) @(posedge core_clk);
    chk1(prog_busy, 1'b1);
    ce <= 1'b1;
    poll();
    rd_open(11'h7F5);
    mst.rd(1'b1, d);
    mst.stop();
    chk8(d, 8'h3C);
    $display("t_byte done");
  endtask

  // Eighteen bytes from slot 14 wrap and overwrite slots 14 and 15
  task automatic t_page();
    addr(11'h11E);
    for (int i = 0; i < 18; i++) begin
      mst.wr(8'(8'h40 + i), ack);
      chk1(ack, 1'b1);
    end
    mst.stop();
    poll();
    rd_open(11'h110);
    for (int s = 0; s < 16; s++) begin
      mst.rd(s == 15, d);
      chk8(d, 8'(8'h42 + s));
    end
    mst.stop();
    $display("t_page done");
  endtask

  task automatic t_wrap();
    wr_at(11'h7FF, 8'h5A);
    wr_at(11'h000, 8'hA5);
    rd_open(11'h7FF);
    mst.rd(1'b1, d);
    mst.stop();
    mst.start();
    mst.wr(8'hA1, ack);
    chk1(ack, 1'b1);
    mst.rd(1'b1, d);
    mst.stop();
    chk8(d, 8'hA5);
    rd_open(11'h7FF);
    mst.rd(1'b0, d);
    chk8(d, 8'h5A);
    mst.rd(1'b1, d);
    mst.stop();
    chk8(d, 8'hA5);
    $display("t_wrap done");
  endtask

  task automatic t_refuse();
    mst.start();
    mst.wr(8'hB0, ack);
    chk1(ack, 1'b0);
    mst.wr(8'h00, ack);
    chk1(ack, 1'b0);
    mst.stop();
    wr_at(11'h455, 8'h11);
    wp_in <= 1'b1;
    wr_at(11'h455, 8'h22);
    wp_in <= 1'b0;
    rd_open(11'h455);
    mst.rd(1'b1, d);
    mst.stop();
    chk8(d, 8'h11);
    $display("t_refuse done");
  endtask

  task automatic wrap_up();
    $display("counts: tests=%0d errors=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    wp_in = 1'b0;
    cs_pins = 3'h5;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    t_byte();
    t_page();
    t_wrap();
    t_refuse();
    wrap_up();
  end
endmodule
